// ==== core/dcpr_regs.vh ====
// Constants for the daisy-chain poll responder: field positions and timing budgets.
// Assumes a single system clock; times are given in nanoseconds.
`ifndef DCPR_REGS_VH
`define DCPR_REGS_VH

// ==========================================================
// Poll identifier field layout
`define DCPR_PID_W 4
`define DCPR_PID_LVL_LO 0
`define DCPR_PID_LVL_HI 1
`define DCPR_PID_INTR 2
`define DCPR_PID_CS 3

// ==========================================================
// Interrupt levels and reset values
`define DCPR_LVL_W 2
`define DCPR_NUM_LVL 4
`define DCPR_LVL_RST 2'h0
`define DCPR_MASK_RST 1'b0

// ==========================================================
// Timing budgets (ns) and the cycle counts derived from them
`define DCPR_CLK_NS 25
`define DCPR_T_FREEZE_NS 100
`define DCPR_T_CAPTURE_NS 100
`define DCPR_T_RET_DROP_NS 100
`define DCPR_T_PROPAGATE_NS 200
`define DCPR_T_RESET_NS 200
`define DCPR_CYC_CAPTURE (`DCPR_T_CAPTURE_NS / `DCPR_CLK_NS)
`define DCPR_CYC_PROPAGATE (`DCPR_T_PROPAGATE_NS / `DCPR_CLK_NS)
`define DCPR_CYC_RESET (`DCPR_T_RESET_NS / `DCPR_CLK_NS)
// Synchroniser depth in flip-flops.
`define DCPR_SYNC_DEPTH 3

`endif

// ==== core/dcpr_sync.v ====
// Three-stage synchroniser with agreement filter for asynchronous channel lines.
// Assumes inputs may change at any time relative to sys_clk.
`default_nettype none

module dcpr_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Lines
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] filt
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    reg [WIDTH-1:0] held;
    integer i;
    reg [WIDTH-1:0] next_held;

    // ==========================================================
    // Stage chain; stage1 is read only by stage2.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            held <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            held <= next_held;
        end
    end

    // ==========================================================
    // A change counts only once the second and third stages agree.
    always @* begin
        next_held = held;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
                next_held[i] = stage3[i];
            end
        end
    end

    assign filt = next_held;

endmodule // dcpr_sync
`default_nettype wire

// ==== core/dcpr_top.v ====
// Poll responder of a daisy-chained channel attachment: requests, capture and propagation.
// Assumes channel lines are asynchronous; device-side strobes are on sys_clk.
`default_nettype none
`include "dcpr_regs.vh"

// Function
// - Interrupt request on configured level when unmasked.
// - Interrupt request holds until capture or clear.
// - Reset or setup moves request within strobe.
// - Cycle-steal request holds until capture or reset.
// - Device reset keeps dummy output transfer last.
// - Freeze request state when poll identifier rises.
// - Poll edge decides capture or pass.
// - Pass copies poll downstream, then ignores polling.
// - Channel resets drop downstream poll at once.
// - Capture drops request, asserts return quickly.
// - Single-service return drops after poll falls.
// - No new request until service ends.
// - Burst keeps servicing this attachment until dropped.
// - Burst return drops at final service gate.
// - No request until final service ends.
// - Any reset but device reset withdraws all driven lines quickly.
module dcpr_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Channel lines, asynchronous
    input wire [`DCPR_PID_W-1:0] poll_identifier,
    input wire poll,
    input wire service_gate,
    input wire machine_check_halt,
    input wire system_reset,
    input wire power_on_reset,
    // Device-side controls, on sys_clk
    input wire intr_cond,
    input wire cs_need,
    input wire burst_mode,
    input wire final_xfer,
    input wire service_gate_return,
    input wire device_reset,
    input wire setup_cmd,
    input wire setup_mask,
    input wire [`DCPR_LVL_W-1:0] setup_level,
    // Channel outputs
    output reg [`DCPR_NUM_LVL-1:0] request_in,
    output reg cs_request,
    output reg poll_propagate,
    output reg poll_return,
    output reg burst_return,
    // Device-side status
    output reg dummy_xfer,
    output reg captured_intr,
    output reg captured_cs
);

    localparam ST_IDLE = 3'd0;
    localparam ST_PASS = 3'd1;
    localparam ST_SINGLE = 3'd2;
    localparam ST_BURST = 3'd3;
    localparam ST_WAIT = 3'd4;

    wire [`DCPR_PID_W-1:0] pid_f;
    wire [2:0] line_f;
    wire poll_f;
    wire sg_f;
    wire chan_rst;
    reg [2:0] state;
    reg [2:0] next_state;
    reg poll_d;
    reg sg_d;
    reg pid_intr_d;
    reg pid_cs_d;
    reg mask;
    reg [`DCPR_LVL_W-1:0] level;
    reg intr_want;
    reg cs_want;
    reg dummy_pend;
    reg snap_intr;
    reg snap_cs;
    reg [`DCPR_LVL_W-1:0] snap_level;
    reg sgr_seen;
    wire poll_rise;
    wire poll_fall;
    wire sg_rise;
    wire blocked;
    wire take_intr;
    wire take_cs;

    function [`DCPR_NUM_LVL-1:0] level_bit;
        input [`DCPR_LVL_W-1:0] lvl;
        begin
            level_bit = {{(`DCPR_NUM_LVL-1){1'b0}}, 1'b1} << lvl;
        end
    endfunction

    // ==========================================================
    // Synchronisers
    // synchronise channel lines
    dcpr_sync #(
        .WIDTH(`DCPR_PID_W)
    ) u_sync_pid (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(poll_identifier),
        .filt(pid_f)
    );

    dcpr_sync #(
        .WIDTH(5)
    ) u_sync_lines (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in({poll, service_gate, machine_check_halt, system_reset, power_on_reset}),
        .filt({poll_f, sg_f, line_f})
    );

    assign chan_rst = |line_f;
    assign poll_rise = poll_f & ~poll_d;
    assign poll_fall = ~poll_f & poll_d;
    assign sg_rise = sg_f & ~sg_d;
    assign blocked = (state == ST_SINGLE) || (state == ST_BURST) || (state == ST_WAIT);

    assign take_intr = pid_f[`DCPR_PID_INTR] & snap_intr
        & (pid_f[`DCPR_PID_LVL_HI:`DCPR_PID_LVL_LO] == snap_level);
    assign take_cs = pid_f[`DCPR_PID_CS] & snap_cs;

    // ==========================================================
    // Poll state machine
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (poll_rise) begin
                    if (take_intr || (take_cs && !burst_mode)) begin
                        next_state = ST_SINGLE;
                    end else if (take_cs) begin
                        next_state = ST_BURST;
                    end else begin
                        next_state = ST_PASS;
                    end
                end
            end
            ST_PASS: begin
                if (!poll_f) begin
                    next_state = ST_IDLE;
                end
            end
            ST_SINGLE: begin
                if (poll_fall) begin
                    next_state = ST_WAIT;
                end
            end
            ST_BURST: begin
                if (sg_rise && (final_xfer || dummy_pend)) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (sgr_seen && !service_gate_return) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            poll_d <= 1'b0;
            sg_d <= 1'b0;
            pid_intr_d <= 1'b0;
            pid_cs_d <= 1'b0;
            snap_intr <= 1'b0;
            snap_cs <= 1'b0;
            snap_level <= `DCPR_LVL_RST;
            sgr_seen <= 1'b0;
            poll_propagate <= 1'b0;
            poll_return <= 1'b0;
            burst_return <= 1'b0;
            captured_intr <= 1'b0;
            captured_cs <= 1'b0;
        end else if (chan_rst) begin
            state <= ST_IDLE;
            poll_d <= poll_f;
            sg_d <= sg_f;
            pid_intr_d <= 1'b0;
            pid_cs_d <= 1'b0;
            snap_intr <= 1'b0;
            snap_cs <= 1'b0;
            sgr_seen <= 1'b0;
            poll_propagate <= 1'b0;
            poll_return <= 1'b0;
            burst_return <= 1'b0;
            captured_intr <= 1'b0;
            captured_cs <= 1'b0;
        end else begin
            state <= next_state;
            poll_d <= poll_f;
            sg_d <= sg_f;
            pid_intr_d <= pid_f[`DCPR_PID_INTR];
            pid_cs_d <= pid_f[`DCPR_PID_CS];
            if (pid_f[`DCPR_PID_INTR] && !pid_intr_d) begin
                snap_intr <= intr_want & mask & ~blocked;
                snap_level <= level;
            end
            if (pid_f[`DCPR_PID_CS] && !pid_cs_d) begin
                snap_cs <= cs_want & ~blocked;
            end
            if (service_gate_return) begin
                sgr_seen <= 1'b1;
            end else if (next_state == ST_WAIT && state != ST_WAIT) begin
                sgr_seen <= 1'b0;
            end
            poll_propagate <= (next_state == ST_PASS) & poll_f;
            poll_return <= (next_state == ST_SINGLE);
            burst_return <= (next_state == ST_BURST);
            if (state == ST_IDLE && poll_rise) begin
                captured_intr <= take_intr;
                captured_cs <= take_cs & ~take_intr;
            end else if (next_state == ST_IDLE) begin
                captured_intr <= 1'b0;
                captured_cs <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Request holding
    always @(posedge sys_clk) begin
        if (!rst_b || chan_rst) begin
            mask <= `DCPR_MASK_RST;
            level <= `DCPR_LVL_RST;
            intr_want <= 1'b0;
            cs_want <= 1'b0;
            dummy_pend <= 1'b0;
            dummy_xfer <= 1'b0;
            request_in <= {`DCPR_NUM_LVL{1'b0}};
            cs_request <= 1'b0;
        end else begin
            if (setup_cmd) begin
                mask <= setup_mask;
                level <= setup_level;
            end
            if (intr_cond) begin
                intr_want <= 1'b1;
            end else if (device_reset || (setup_cmd && !setup_mask)) begin
                intr_want <= 1'b0;
            end else if (state == ST_IDLE && poll_rise && take_intr) begin
                intr_want <= 1'b0;
            end
            if (cs_need) begin
                cs_want <= 1'b1;
            end else if (state == ST_IDLE && poll_rise && take_cs && !take_intr) begin
                cs_want <= 1'b0;
            end
            // device reset leaves a dummy transfer when cs_want is set or the state is ST_BURST
            if (device_reset && (cs_want || state == ST_BURST)) begin
                dummy_pend <= 1'b1;
            end else if (state == ST_WAIT && next_state == ST_IDLE) begin
                dummy_pend <= 1'b0;
            end
            dummy_xfer <= dummy_pend | (device_reset & (cs_want | (state == ST_BURST)));
            if (next_state == ST_SINGLE || next_state == ST_BURST || blocked
                || device_reset || (setup_cmd && !setup_mask)) begin
                request_in <= {`DCPR_NUM_LVL{1'b0}};
            end else if (setup_cmd) begin
                request_in <= (intr_want | intr_cond) ? level_bit(setup_level)
                    : {`DCPR_NUM_LVL{1'b0}};
            end else begin
                request_in <= ((intr_want | intr_cond) & mask) ? level_bit(level)
                    : {`DCPR_NUM_LVL{1'b0}};
            end
            cs_request <= (cs_want | cs_need) & ~blocked
                & ~(next_state == ST_SINGLE || next_state == ST_BURST);
        end
    end

endmodule // dcpr_top
`default_nettype wire

// ==== verif/dcpr_monitor.sv ====
// Port checker for dcpr_top.
// Assumes it is bound to dcpr_top and sees the channel lines unsynchronised.
`default_nettype none
`include "dcpr_regs.vh"
module dcpr_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Inputs watched
    input wire logic poll,
    input wire logic service_gate,
    input wire logic machine_check_halt,
    input wire logic system_reset,
    input wire logic power_on_reset,
    input wire logic final_xfer,
    // Outputs watched
    input wire logic [`DCPR_NUM_LVL-1:0] request_in,
    input wire logic cs_request,
    input wire logic poll_propagate,
    input wire logic poll_return,
    input wire logic burst_return,
    input wire logic dummy_xfer,
    input wire logic captured_intr,
    input wire logic captured_cs
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Sequences and properties
    sequence s_chan_rst; machine_check_halt || system_reset || power_on_reset; endsequence
    sequence s_poll_up; $rose(poll); endsequence
    property p_rst_quiet;
        disable iff (1'h0) !rst_b |=> !(poll_return || burst_return || poll_propagate);
    endproperty
    property p_chan_rst;
        s_chan_rst |-> ##[0:4] (!poll_propagate && !cs_request && request_in == 4'h0);
    endproperty
    property p_answer; s_poll_up |-> ##[1:4] (poll_return || burst_return || poll_propagate); endproperty
    property p_drop_first; $rose(poll_return) && captured_intr |-> request_in == 4'h0; endproperty
    property p_ret_fall; $fell(poll) && poll_return |-> ##[1:4] !poll_return; endproperty
    property p_burst_end;
        burst_return && $rose(service_gate) && (final_xfer || dummy_xfer) |-> ##[1:4] !burst_return;
    endproperty
    property p_no_new;
        (captured_intr || captured_cs) |-> !$rose(cs_request) && !$rose(|request_in);
    endproperty
    property p_one_level; $onehot0(request_in); endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
    a_chan_rst: assert property (p_chan_rst) else $error("channel reset slow");
    a_answer: assert property (p_answer) else $error("poll not answered");
    a_drop_first: assert property (p_drop_first) else $error("request left up");
    a_ret_fall: assert property (p_ret_fall) else $error("return held");
    a_burst_end: assert property (p_burst_end) else $error("burst return held");
    a_no_new: assert property (p_no_new) else $error("request during service");
    a_one_level: assert property (p_one_level) else $error("two levels requested");
endmodule // dcpr_monitor
`default_nettype wire

// ==== verif/dcpr_chan_model.sv ====
// Channel model: drives poll identifier, poll, service gate and halt line.
// Assumes the device answers on registered outputs of dcpr_top.
`default_nettype none
`include "dcpr_regs.vh"
module dcpr_chan_model (
    // Clock
    input wire logic sys_clk,
    // Device answers
    input wire logic poll_return,
    input wire logic burst_return,
    input wire logic poll_propagate,
    // Channel lines
    output logic [`DCPR_PID_W-1:0] poll_identifier,
    output logic poll,
    output logic service_gate,
    output logic machine_check_halt
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        poll_identifier = 4'h0;
        poll = 1'h0;
        service_gate = 1'h0;
        machine_check_halt = 1'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic poll_seq(input logic [`DCPR_PID_W-1:0] pid, output logic [2:0] ans);
        ans = 3'h0;
        step(1);
        poll_identifier = pid;
        step(8);
        poll = 1'h1;
        for (int i = 0; i < 8 && ans == 3'h0; i++) begin
            step(1);
            ans = {poll_return, burst_return, poll_propagate};
        end
        machine_check_halt = (ans == 3'h0);
        step(10);
        poll = 1'h0;
        machine_check_halt = 1'h0;
        step(5);
        poll_identifier = 4'h0;
        step(5);
    endtask
    task automatic gate();
        step(1);
        service_gate = 1'h1;
        step(8);
        service_gate = 1'h0;
        step(4);
    endtask
endmodule // dcpr_chan_model
`default_nettype wire

// ==== verif/dcpr_top_tb.sv ====
// Testbench for dcpr_top with a channel model on the poll lines.
// Assumes a 40 MHz sys_clk; inputs change 1 ns after a rising edge.
`default_nettype none
`include "dcpr_regs.vh"
module dcpr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [`DCPR_PID_W-1:0] poll_identifier;
    logic poll, service_gate, machine_check_halt;
    logic system_reset = 1'h0, power_on_reset = 1'h0, intr_cond = 1'h0, cs_need = 1'h0;
    logic burst_mode = 1'h0, final_xfer = 1'h0, service_gate_return = 1'h0;
    logic device_reset = 1'h0, setup_cmd = 1'h0, setup_mask = 1'h0;
    logic [`DCPR_LVL_W-1:0] setup_level = 2'h0;
    logic [`DCPR_NUM_LVL-1:0] request_in;
    logic cs_request, poll_propagate, poll_return, burst_return;
    logic dummy_xfer, captured_intr, captured_cs;
    logic [2:0] ans;
    int checks = 0;
    int miscompares = 0;
    always #12.5 sys_clk = ~sys_clk;
    dcpr_top dut_u (.sys_clk, .rst_b, .poll_identifier, .poll, .service_gate,
        .machine_check_halt, .system_reset, .power_on_reset, .intr_cond, .cs_need,
        .burst_mode, .final_xfer, .service_gate_return, .device_reset, .setup_cmd,
        .setup_mask, .setup_level, .request_in, .cs_request, .poll_propagate,
        .poll_return, .burst_return, .dummy_xfer, .captured_intr, .captured_cs);
    dcpr_chan_model chan_u (.sys_clk, .poll_return, .burst_return, .poll_propagate,
        .poll_identifier, .poll, .service_gate, .machine_check_halt);
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick(1);
        s = 1'h0;
        tick(1);
    endtask
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic svc();
        fork
            chan_u.gate();
            begin
                tick(4);
                service_gate_return = 1'h1;
            end
        join
        tick(2);
        service_gate_return = 1'h0;
        tick(3);
    endtask
    task automatic t_intr();
        setup_mask = 1'h1;
        setup_level = 2'h2;
        pulse(setup_cmd);
        pulse(intr_cond);
        chk("request_in", request_in, 4'h4);
        chan_u.poll_seq(4'h6, ans);
        chk("answer", 4'(ans), 4'h4);
        chk("captured_intr", 4'(captured_intr), 4'h1);
        chk("poll_return", 4'(poll_return), 4'h0);
        pulse(intr_cond);
        chk("request_in", request_in, 4'h0);
        svc();
        pulse(intr_cond);
        chk("request_in", request_in, 4'h4);
        $display("interrupt capture done");
    endtask
    task automatic t_pass();
        chan_u.poll_seq(4'h5, ans);
        chk("answer", 4'(ans), 4'h1);
        chk("poll_propagate", 4'(poll_propagate), 4'h0);
        chk("request_in", request_in, 4'h4);
        setup_level = 2'h1;
        pulse(setup_cmd);
        chk("request_in", request_in, 4'h2);
        setup_mask = 1'h0;
        pulse(setup_cmd);
        chk("request_in", request_in, 4'h0);
        pulse(intr_cond);
        chk("request_in", request_in, 4'h0);
        $display("pass and mask done");
    endtask
    task automatic t_freeze();
        fork
            chan_u.poll_seq(4'h8, ans);
            begin
                tick(6);
                pulse(cs_need);
            end
        join
        chk("answer", 4'(ans), 4'h1);
        chk("cs_request", 4'(cs_request), 4'h1);
        $display("late request done");
    endtask
    task automatic t_burst();
        burst_mode = 1'h1;
        chan_u.poll_seq(4'h8, ans);
        chk("answer", 4'(ans), 4'h2);
        chk("captured_cs", 4'(captured_cs), 4'h1);
        chk("cs_request", 4'(cs_request), 4'h0);
        pulse(cs_need);
        svc();
        chk("burst_return", 4'(burst_return), 4'h1);
        chk("cs_request", 4'(cs_request), 4'h0);
        pulse(device_reset);
        chk("dummy_xfer", 4'(dummy_xfer), 4'h1);
        svc();
        chk("burst_return", 4'(burst_return), 4'h0);
        pulse(cs_need);
        chk("cs_request", 4'(cs_request), 4'h1);
        chan_u.poll_seq(4'h8, ans);
        chk("answer", 4'(ans), 4'h2);
        final_xfer = 1'h1;
        svc();
        chk("burst_return", 4'(burst_return), 4'h0);
        final_xfer = 1'h0;
        burst_mode = 1'h0;
        $display("burst done");
    endtask
    task automatic t_reset();
        pulse(cs_need);
        chk("cs_request", 4'(cs_request), 4'h1);
        rst_b = 1'h0;
        tick(2);
        chk("outputs", {poll_return, burst_return, poll_propagate, cs_request}, 4'h0);
        rst_b = 1'h1;
        pulse(cs_need);
        chk("cs_request", 4'(cs_request), 4'h1);
        fork
            chan_u.poll_seq(4'h5, ans);
            begin
                tick(14);
                chk("poll_propagate", 4'(poll_propagate), 4'h1);
                chk("cs_request", 4'(cs_request), 4'h1);
                power_on_reset = 1'h1;
                tick(5);
                chk("poll_propagate", 4'(poll_propagate), 4'h0);
                chk("cs_request", 4'(cs_request), 4'h0);
                power_on_reset = 1'h0;
            end
        join
        $display("resets done");
    endtask
    initial begin
        tick(8);
        rst_b = 1'h1;
        t_intr();
        t_pass();
        t_freeze();
        t_burst();
        t_reset();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end
endmodule // dcpr_top_tb
bind dcpr_top dcpr_monitor mon_u (.sys_clk, .rst_b, .poll, .service_gate, .machine_check_halt,
    .system_reset, .power_on_reset, .final_xfer, .request_in, .cs_request, .poll_propagate,
    .poll_return, .burst_return, .dummy_xfer, .captured_intr, .captured_cs);
`default_nettype wire
